// ==== hdl/flash_selfprog_defs.vh ====
// constants for the flash self-programming sequencer
// Summary of operation
// - flash program commands are refused while an eeprom write is busy
// - fuse and lock readback is blocked while an eeprom write is busy
// - pointer 0x0001 with readback armed returns lock bits on load
// - armed bits clear after readback, three idle load or four store cycles
// - with readback disarmed a load reads ordinary program memory
// - pointer 0x0000 with readback armed returns fuse low byte
// - pointer 0x0003 returns fuse high byte, bit n to bit n
// - pointer 0x0002 returns extended fuse byte
// - programmed bits read as zero, unprogrammed bits read as one
// - a flash write in progress completes even across reset
// - erase, write and lock write take 3.7 ms to 4.5 ms
// - during erase or write only the no-rww section is readable
// - erase or write to rww sets busy until a re-enable or a plain enable store clears it
`ifndef FLASH_SELFPROG_DEFS_VH
`define FLASH_SELFPROG_DEFS_VH
// ------------------------------------------------------------
// control register bit positions
// ------------------------------------------------------------
`define SPC_ENABLE_BIT 0
`define SPC_ERASE_BIT 1
`define SPC_WRITE_BIT 2
`define SPC_LOCKSET_BIT 3
`define SPC_REENABLE_BIT 4
`define SPC_BUSY_BIT 6
`define SPC_IE_BIT 7
`define SPC_RESET_VAL 8'h00
// ------------------------------------------------------------
// readback pointers
// ------------------------------------------------------------
`define PTR_FUSE_LOW 16'h0000
`define PTR_LOCK 16'h0001
`define PTR_FUSE_EXT 16'h0002
`define PTR_FUSE_HIGH 16'h0003
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define LOAD_WINDOW 3
`define STORE_WINDOW 4
`define CLK_KHZ 40000
`define PROG_TIME_MIN_US 3700
`define PROG_TIME_MAX_US 4500
`define PROG_CYCLES_MIN ((`PROG_TIME_MIN_US * `CLK_KHZ + 999) / 1000)
`define PROG_CYCLES_MAX ((`PROG_TIME_MAX_US * `CLK_KHZ) / 1000)
// default count sits inside the window, sized to the 18-bit timer
`define PROG_CYCLES_DEF 18'd150000
`endif

// ==== hdl/prog_timer.v ====
// programming duration timer, counts one flash operation
`timescale 1ns/10ps
`default_nettype none
module prog_timer #(
   parameter [17:0] PROG_CYCLES = 18'd160000
) (
   input wire mclk_in,
   input wire start_in,
   output reg busy_out,
   output reg done_out
);
   reg [17:0] count_q;
   // -----------------------------------------------
   // counter deliberately not reset so writes finish
   // -----------------------------------------------
   initial begin
      count_q = 18'h00000;
      busy_out = 1'b0;
      done_out = 1'b0;
   end
   always @(posedge mclk_in) begin
      done_out <= 1'b0;
      if (start_in && !busy_out) begin
         count_q <= PROG_CYCLES - 18'd1;
         busy_out <= 1'b1;
      end else if (busy_out) begin
         if (count_q == 18'h00000) begin
            busy_out <= 1'b0;
            done_out <= 1'b1;
         end else begin
            count_q <= count_q - 18'd1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== hdl/flash_selfprog_fuse_readback.v ====
// flash self-programming sequencer with fuse and lock readback
`timescale 1ns/10ps
`default_nettype none
`include "flash_selfprog_defs.vh"
module flash_selfprog_fuse_readback #(
   parameter [17:0] PROG_CYCLES = `PROG_CYCLES_DEF
) (
   input wire mclk_in,
   input wire rst_in,
   input wire ctrl_wr_in,
   input wire [7:0] ctrl_wdata_in,
   input wire eeprom_write_busy_flag_in,
   input wire store_in,
   input wire load_in,
   input wire [15:0] zptr_in,
   input wire [7:0] r0_in,
   input wire rww_target_in,
   input wire fetch_rww_in,
   input wire [7:0] pm_rdata_in,
   input wire [7:0] lock_bits_in,
   input wire [7:0] fuse_low_byte_in,
   input wire [7:0] fuse_high_byte_in,
   input wire [7:0] fuse_extended_byte_in,
   output reg [7:0] ctrl_rdata_out,
   output reg [7:0] load_data_out,
   output reg load_valid_out,
   output reg fetch_allowed_out,
   output reg cpu_halt_out,
   output reg lock_wr_out,
   output reg [7:0] lock_wdata_out,
   output reg erase_out,
   output reg page_write_out
);
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_ARMED = 4'b0010;
   localparam [3:0] ST_PROG = 4'b0100;
   localparam [3:0] ST_DONE = 4'b1000;
   reg [3:0] state_q;
   reg [4:0] cmd_q;
   reg ie_q;
   reg [2:0] win_q;
   reg rww_busy_flag_q;
   reg prog_rww_q;
   reg start_q;
   wire timer_busy;
   wire timer_done;
   wire lock_bit_set;
   wire self_program_enable;
   wire ctrl_wr_ok;
   wire readback;
   wire [4:0] new_cmd;
   reg [7:0] rb_data;
   assign self_program_enable = cmd_q[`SPC_ENABLE_BIT];
   assign lock_bit_set = cmd_q[`SPC_LOCKSET_BIT];
   assign new_cmd = ctrl_wdata_in[4:0];
   assign ctrl_wr_ok = ctrl_wr_in && !eeprom_write_busy_flag_in;
   assign readback = (state_q == ST_ARMED) && lock_bit_set &&
      self_program_enable && (win_q < `LOAD_WINDOW) &&
      !eeprom_write_busy_flag_in;
   // -----------------------------------------------
   // fuse and lock source select, bits passed as stored
   // -----------------------------------------------
   always @* begin
      case (zptr_in)
         `PTR_FUSE_LOW: rb_data = fuse_low_byte_in;
         `PTR_LOCK: rb_data = lock_bits_in;
         `PTR_FUSE_EXT: rb_data = fuse_extended_byte_in;
         `PTR_FUSE_HIGH: rb_data = fuse_high_byte_in;
         default: rb_data = 8'hff;
      endcase
   end
   // -----------------------------------------------
   // programming timer, survives reset
   // -----------------------------------------------
   prog_timer #(
      .PROG_CYCLES(PROG_CYCLES)
   ) u_timer (
      .mclk_in(mclk_in),
      .start_in(start_q),
      .busy_out(timer_busy),
      .done_out(timer_done)
   );
   // -----------------------------------------------
   // command sequencer
   // -----------------------------------------------
   always @(posedge mclk_in) begin
      start_q <= 1'b0;
      load_valid_out <= 1'b0;
      lock_wr_out <= 1'b0;
      erase_out <= 1'b0;
      page_write_out <= 1'b0;
      if (rst_in) begin
         state_q <= ST_IDLE;
         cmd_q <= 5'h00;
         ie_q <= 1'b0;
         win_q <= 3'h0;
         rww_busy_flag_q <= 1'b0;
         prog_rww_q <= 1'b0;
         load_data_out <= 8'h00;
         lock_wdata_out <= 8'hff;
      end else begin
         if (load_in) begin
            load_valid_out <= 1'b1;
            if (readback)
               load_data_out <= rb_data;
            else
               load_data_out <= pm_rdata_in;
         end
         case (state_q)
            ST_IDLE: begin
               if (ctrl_wr_ok) begin
                  ie_q <= ctrl_wdata_in[`SPC_IE_BIT];
                  if (new_cmd[`SPC_ENABLE_BIT]) begin
                     cmd_q <= new_cmd;
                     win_q <= 3'h0;
                     state_q <= ST_ARMED;
                  end
               end
            end
            ST_ARMED: begin
               win_q <= win_q + 3'h1;
               if (eeprom_write_busy_flag_in) begin
                  cmd_q <= 5'h00;
                  state_q <= ST_IDLE;
               end else if (readback && load_in) begin
                  cmd_q <= 5'h00;
                  state_q <= ST_IDLE;
               end else if (store_in && win_q < `STORE_WINDOW) begin
                  if (cmd_q[`SPC_ERASE_BIT] ||
                      cmd_q[`SPC_WRITE_BIT]) begin
                     start_q <= 1'b1;
                     erase_out <= cmd_q[`SPC_ERASE_BIT];
                     page_write_out <= cmd_q[`SPC_WRITE_BIT];
                     prog_rww_q <= rww_target_in;
                     if (rww_target_in)
                        rww_busy_flag_q <= 1'b1;
                     state_q <= ST_PROG;
                  end else if (lock_bit_set) begin
                     start_q <= 1'b1;
                     lock_wr_out <= 1'b1;
                     lock_wdata_out <= r0_in;
                     prog_rww_q <= 1'b0;
                     state_q <= ST_PROG;
                  end else begin
                     if (cmd_q[`SPC_REENABLE_BIT] && !timer_busy)
                        rww_busy_flag_q <= 1'b0;
                     else if (!cmd_q[`SPC_REENABLE_BIT])
                        rww_busy_flag_q <= 1'b0;
                     cmd_q <= 5'h00;
                     state_q <= ST_IDLE;
                  end
               end else if ((lock_bit_set &&
                  win_q >= `LOAD_WINDOW - 1) ||
                  win_q >= `STORE_WINDOW - 1) begin
                  cmd_q <= 5'h00;
                  state_q <= ST_IDLE;
               end
            end
            ST_PROG: begin
               if (timer_done)
                  state_q <= ST_DONE;
            end
            ST_DONE: begin
               cmd_q <= 5'h00;
               state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
   // -----------------------------------------------
   // status and fetch gating
   // -----------------------------------------------
   always @(posedge mclk_in) begin
      if (rst_in) begin
         ctrl_rdata_out <= `SPC_RESET_VAL;
         fetch_allowed_out <= 1'b1;
         cpu_halt_out <= 1'b0;
      end else begin
         ctrl_rdata_out <= {ie_q, rww_busy_flag_q, 1'b0, cmd_q};
         fetch_allowed_out <= !(fetch_rww_in &&
            (rww_busy_flag_q || timer_busy));
         cpu_halt_out <= timer_busy && !prog_rww_q &&
            (state_q == ST_PROG) && !lock_wr_out;
      end
   end
endmodule
`default_nettype wire

// ==== tb/flash_selfprog_props.sv ====
// port assertions for the flash self-programming sequencer
`timescale 1ns/10ps
`default_nettype none
module flash_selfprog_checker (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic ctrl_wr_in,
   input wire logic [7:0] ctrl_wdata_in,
   input wire logic eeprom_write_busy_flag_in,
   input wire logic store_in,
   input wire logic load_in,
   input wire logic [15:0] zptr_in,
   input wire logic rww_target_in,
   input wire logic fetch_rww_in,
   input wire logic [7:0] pm_rdata_in,
   input wire logic [7:0] lock_bits_in,
   input wire logic [7:0] ctrl_rdata_out,
   input wire logic [7:0] load_data_out,
   input wire logic load_valid_out,
   input wire logic fetch_allowed_out,
   input wire logic erase_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   wire logic ee = eeprom_write_busy_flag_in;
   sequence s_arm;
      ctrl_wr_in && ctrl_wdata_in == 8'h09 && !ee && !ctrl_rdata_out[0];
   endsequence
   sequence s_rww_erase;
      erase_out && $past(rww_target_in);
   endsequence
   property p_valid;
      load_in |=> load_valid_out;
   endproperty
   property p_lock;
      s_arm ##1 (load_in && zptr_in == 16'h0001 && !ee)
         |=> load_data_out == $past(lock_bits_in);
   endproperty
   property p_timeout;
      s_arm ##1 (!load_in && !store_in && !ctrl_wr_in)[*6]
         |=> ctrl_rdata_out[3:0] == 4'h0;
   endproperty
   property p_plain;
      (!(ctrl_wr_in && ctrl_wdata_in[0]))[*5] ##1 load_in
         |=> load_data_out == $past(pm_rdata_in);
   endproperty
   property p_ee_rb;
      ee && load_in |=> load_data_out == $past(pm_rdata_in);
   endproperty
   property p_ee_cmd;
      ee && store_in |=> !erase_out;
   endproperty
   property p_busy;
      s_rww_erase |-> ##[0:2] ctrl_rdata_out[6];
   endproperty
   property p_block;
      s_rww_erase ##2 fetch_rww_in |=> !fetch_allowed_out;
   endproperty
   a_valid: assert property (p_valid) else $error("no load answer");
   a_lock: assert property (p_lock) else $error("lock readback");
   a_timeout: assert property (p_timeout) else $error("arm stuck");
   a_plain: assert property (p_plain) else $error("plain load");
   a_ee_rb: assert property (p_ee_rb) else $error("readback open");
   a_ee_cmd: assert property (p_ee_cmd) else $error("erase ran");
   a_busy: assert property (p_busy) else $error("busy not set");
   a_block: assert property (p_block) else $error("fetch open");
endmodule
bind flash_selfprog_fuse_readback flash_selfprog_checker u_chk (.*);
`default_nettype wire

// ==== tb/cpu_model.sv ====
// cpu core issuing timed control writes, each with an optional load or store
`timescale 1ns/10ps
`default_nettype none
module cpu_model (
   input wire logic mclk_in,
   input wire logic ee_busy_in,
   input wire logic [7:0] ctrl_rdata_in,
   output logic ctrl_wr_out,
   output logic [7:0] ctrl_wdata_out,
   output logic load_out,
   output logic store_out,
   output logic [15:0] zptr_out,
   output logic [7:0] r0_out
);
   initial {ctrl_wr_out, load_out, store_out, ctrl_wdata_out, zptr_out} = '0;
   initial r0_out = 8'hc3;
   // op 1 load, 2 store, 0 none; no interrupt splits the pair
   task automatic seq(input logic [7:0] cmd, input logic [15:0] ptr,
                      input logic [1:0] op, input logic polite);
      int n;
      begin
         n = 0;
         while (n < 400 && polite && (ctrl_rdata_in[0] | ee_busy_in)) begin
            @(posedge mclk_in);
            n++;
         end
         @(posedge mclk_in);
         zptr_out <= ptr;
         ctrl_wdata_out <= cmd;
         ctrl_wr_out <= 1'b1;
         @(posedge mclk_in);
         ctrl_wr_out <= 1'b0;
         load_out <= (op == 2'd1);
         store_out <= (op == 2'd2);
         @(posedge mclk_in);
         load_out <= 1'b0;
         store_out <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ==== tb/flash_selfprog_fuse_readback_test.sv ====
// self-checking bench for the flash self-programming sequencer
`timescale 1ns/10ps
`default_nettype none
module flash_selfprog_fuse_readback_test;
   localparam int PROG = 20;
   logic [7:0] rb [4] = '{8'h5a, 8'ha4, 8'h3c, 8'hc9};
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic eeprom_write_busy_flag_in = 1'b0;
   logic rww_target_in = 1'b0;
   logic fetch_rww_in = 1'b0;
   logic ctrl_wr_in, store_in, load_in, load_valid_out, fetch_allowed_out;
   logic cpu_halt_out, lock_wr_out, erase_out, page_write_out;
   logic [7:0] ctrl_wdata_in, r0_in, ctrl_rdata_out, load_data_out;
   logic [7:0] lock_wdata_out;
   logic [15:0] zptr_in;
   wire logic [7:0] pm_rdata_in = 8'h6e;
   wire logic [7:0] fuse_low_byte_in = rb[0];
   wire logic [7:0] lock_bits_in = rb[1];
   wire logic [7:0] fuse_extended_byte_in = rb[2];
   wire logic [7:0] fuse_high_byte_in = rb[3];
   int error_cnt = 0;
   int compares = 0;
   always #12.5 mclk_in = ~mclk_in;
   flash_selfprog_fuse_readback #(.PROG_CYCLES(18'd20)) DUT (.*);
   cpu_model cpu (.mclk_in(mclk_in), .ee_busy_in(eeprom_write_busy_flag_in),
      .ctrl_rdata_in(ctrl_rdata_out), .ctrl_wr_out(ctrl_wr_in),
      .ctrl_wdata_out(ctrl_wdata_in), .load_out(load_in),
      .store_out(store_in), .zptr_out(zptr_in), .r0_out(r0_in));
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic settle;
      @(posedge mclk_in);
      #1;
   endtask
   task automatic test_done;
      if (error_cnt == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic t_readback;
      for (int i = 0; i < 4; i++) begin
         cpu.seq(8'h09, 16'(i), 2'd1, 1'b1);
         #1;
         cmp({7'h00, load_valid_out}, 8'h01);
         cmp(load_data_out, rb[i]);
         settle;
         cmp({4'h0, ctrl_rdata_out[3:0]}, 8'h00);
      end
      cpu.seq(8'h09, 16'h0001, 2'd0, 1'b1);
      repeat (7) settle;
      cmp({4'h0, ctrl_rdata_out[3:0]}, 8'h00);
      cpu.seq(8'h00, 16'h0001, 2'd1, 1'b1);
      settle;
      cmp(load_data_out, 8'h6e);
   endtask
   task automatic t_eeprom;
      @(posedge mclk_in) eeprom_write_busy_flag_in <= 1'b1;
      cpu.seq(8'h09, 16'h0001, 2'd1, 1'b0);
      settle;
      cmp(load_data_out, 8'h6e);
      cmp(ctrl_rdata_out, 8'h00);
      cpu.seq(8'h03, 16'h0100, 2'd2, 1'b0);
      #1;
      cmp({7'h00, erase_out}, 8'h00);
      @(posedge mclk_in) eeprom_write_busy_flag_in <= 1'b0;
   endtask
   task automatic t_erase;
      int n;
      begin
         n = 0;
         @(posedge mclk_in) rww_target_in <= 1'b1;
         fetch_rww_in <= 1'b1;
         cpu.seq(8'h03, 16'h0100, 2'd2, 1'b1);
         #1;
         cmp({7'h00, erase_out}, 8'h01);
         settle;
         while (ctrl_rdata_out[0] !== 1'b0 && n < 100) begin
            settle;
            n++;
         end
         cmp({7'h00, n >= PROG - 3 && n <= PROG + 3}, 8'h01);
         cmp({6'h00, ctrl_rdata_out[6], fetch_allowed_out}, 8'h02);
         cpu.seq(8'h11, 16'h0000, 2'd2, 1'b1);
         repeat (3) settle;
         cmp({6'h00, ctrl_rdata_out[6], fetch_allowed_out}, 8'h01);
         @(posedge mclk_in) rww_target_in <= 1'b0;
         cpu.seq(8'h09, 16'h0001, 2'd2, 1'b1);
         #1;
         cmp({7'h00, lock_wr_out}, 8'h01);
         cmp(lock_wdata_out, 8'hc3);
         cpu.seq(8'h05, 16'h0200, 2'd2, 1'b1);
         #1;
         cmp({7'h00, page_write_out}, 8'h01);
         repeat (2) settle;
         cmp({7'h00, cpu_halt_out}, 8'h01);
         // reset in mid-write: the timer must keep the rww fetch blocked
         @(posedge mclk_in) rst_in <= 1'b1;
         @(posedge mclk_in) rst_in <= 1'b0;
         settle;
         cmp({7'h00, fetch_allowed_out}, 8'h00);
         repeat (PROG) settle;
         cmp({7'h00, fetch_allowed_out}, 8'h01);
      end
   endtask
   initial begin
      repeat (3) @(posedge mclk_in);
      rst_in <= 1'b0;
      t_readback;
      t_eeprom;
      t_erase;
      test_done;
   end
   initial begin
      #50000;
      error_cnt++;
      test_done;
   end
endmodule
`default_nettype wire
